// [usart_slave_pkg.sv]
// Package with register map, field positions and shared types of the synchronous slave USART.
package usart_slave_pkg;

   // ==========================================================================
   // Register map (byte addresses)
   // ==========================================================================
   localparam logic [7:0] TX_CTRL_ADDR = 8'h00;
   localparam logic [7:0] RX_CTRL_ADDR = 8'h04;
   localparam logic [7:0] TX_HOLD_ADDR = 8'h08;
   localparam logic [7:0] RX_HOLD_ADDR = 8'h0c;
   localparam logic [7:0] IRQ_CTRL_ADDR = 8'h10;

   // ==========================================================================
   // Field positions
   // ==========================================================================
   localparam int TX_NINTH_POS = 0;
   localparam int TX_SHIFT_EMPTY_POS = 1;
   localparam int SYNC_MODE_POS = 4;
   localparam int TX_ENABLE_POS = 5;
   localparam int TX_NINE_POS = 6;
   localparam int CLK_SRC_POS = 7;
   localparam int RX_NINTH_POS = 0;
   localparam int OVERRUN_POS = 1;
   localparam int CONT_RX_POS = 4;
   localparam int SINGLE_RX_POS = 5;
   localparam int RX_NINE_POS = 6;
   localparam int PORT_EN_POS = 7;
   localparam int TX_IE_POS = 0;
   localparam int RX_IE_POS = 1;
   localparam int GIE_POS = 2;
   localparam int TX_FLAG_POS = 4;
   localparam int RX_FLAG_POS = 5;

   // ==========================================================================
   // Reset values
   // ==========================================================================
   localparam logic [7:0] TX_CTRL_RESET = 8'h00;
   localparam logic [7:0] RX_CTRL_RESET = 8'h00;
   localparam logic [2:0] IRQ_CTRL_RESET = 3'h0;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Transmit engine states.
   typedef enum logic [2:0] {
      TX_IDLE = 3'b001,
      TX_SHIFT = 3'b010,
      TX_LOAD = 3'b100
   } tx_state_t;

   // One nine-bit word with its ninth bit on top.
   typedef struct packed {
      logic ninth;
      logic [7:0] data;
   } word_t;

   // Configuration seen by the shift engine.
   typedef struct packed {
      logic port_en;
      logic sync_mode;
      logic clk_src;
      logic tx_en;
      logic tx_nine;
      logic rx_nine;
      logic cont_rx;
   } cfg_t;

endpackage

// [usart_edge_sync.sv]
// Two-stage synchroniser with edge detection for a pin input.
`timescale 1ns/1ps
`default_nettype none
module usart_edge_sync (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_ce,
   input wire logic i_pin,
   output logic o_level,
   output logic o_rise,
   output logic o_fall
);
   logic meta_q, meta_d;
   logic sync_q, sync_d;
   logic last_q, last_d;

   always_comb begin
      meta_d = i_pin;
      sync_d = meta_q;
      last_d = sync_q;
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         last_q <= 1'b0;
      end else if (i_ce) begin
         meta_q <= meta_d;
         sync_q <= sync_d;
         last_q <= last_d;
      end
   end

   assign o_level = sync_q;
   assign o_rise = sync_q & ~last_q;
   assign o_fall = ~sync_q & last_q;
endmodule
`default_nettype wire

// [usart_sync_slave.sv]
// Synchronous slave USART with an AXI4-Lite register port.
// Operation
// - Shift clock comes only from master.
// - Shifting continues while the core sleeps.
// - Cleared clock source bit selects slave.
// - Transmit behaves like master, except sleep.
// - First word loads shifter immediately, shifts.
// - Second word waits; flag stays clear.
// - After shift-out, load second, set flag.
// - Transmit flag with enable wakes; vectors if global enable.
// - Stored ninth bit sent in 9-bit mode.
// - Single receive enable ignored in slave.
// - Continuous receive accepts words in sleep.
// - Full word moves to holding; wakes.
// - Receive done flag; interrupt only enabled.
// - Ninth bit and errors in status.
// - Holding register presents low eight bits.
// - Errors stay until continuous receive cleared.
`timescale 1ns/1ps
`default_nettype none
module usart_sync_slave
   import usart_slave_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_ce,
   input wire logic i_sleep,
   input wire logic i_shift_clock_pin,
   input wire logic i_rx_data_pin,
   output logic o_tx_data_pin,
   output logic o_tx_data_oe,
   output logic o_wake,
   output logic o_irq_vector,
   input wire logic [7:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [7:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready
);
   // =========================================================================
   // Pin synchronisation
   // =========================================================================
   logic ck_rise, ck_fall, rx_level;

   usart_edge_sync ck_sync (
      .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_pin(i_shift_clock_pin),
      .o_level(), .o_rise(ck_rise), .o_fall(ck_fall)
   );
   usart_edge_sync rx_sync (
      .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_pin(i_rx_data_pin),
      .o_level(rx_level), .o_rise(), .o_fall()
   );

   // =========================================================================
   // Registers
   // =========================================================================
   logic [7:0] tx_ctrl_q, tx_ctrl_d, rx_ctrl_q, rx_ctrl_d;
   logic [2:0] irq_ctrl_q, irq_ctrl_d;
   word_t hold_q, hold_d, tsr_q, tsr_d, rxh_q, rxh_d, rsr_q, rsr_d;
   logic hold_full_q, hold_full_d, tx_flag_q, tx_flag_d, rx_flag_q, rx_flag_d;
   logic overrun_q, overrun_d;
   logic [3:0] tx_cnt_q, tx_cnt_d, rx_cnt_q, rx_cnt_d;
   tx_state_t tx_st_q, tx_st_d;
   cfg_t cfg;
   logic active, tx_last, rx_done;
   logic wr_go, rd_go, hold_wr, rxh_rd;

   // slave selected by cleared clock source bit
   assign cfg = '{port_en: rx_ctrl_q[PORT_EN_POS], sync_mode: tx_ctrl_q[SYNC_MODE_POS],
                  clk_src: tx_ctrl_q[CLK_SRC_POS], tx_en: tx_ctrl_q[TX_ENABLE_POS],
                  tx_nine: tx_ctrl_q[TX_NINE_POS], rx_nine: rx_ctrl_q[RX_NINE_POS],
                  cont_rx: rx_ctrl_q[CONT_RX_POS]};
   assign active = cfg.port_en & cfg.sync_mode & ~cfg.clk_src;

   // =========================================================================
   // AXI4-Lite handshakes
   // =========================================================================
   logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d;
   logic aw_ok, ar_ok;

   assign wr_go = i_awvalid & i_wvalid & ~bvalid_q;
   assign rd_go = i_arvalid & ~rvalid_q;
   assign o_awready = wr_go;
   assign o_wready = wr_go;
   assign o_arready = rd_go;
   assign aw_ok = (i_awaddr == TX_CTRL_ADDR) | (i_awaddr == RX_CTRL_ADDR) |
                  (i_awaddr == TX_HOLD_ADDR) | (i_awaddr == RX_HOLD_ADDR) |
                  (i_awaddr == IRQ_CTRL_ADDR);
   assign ar_ok = (i_araddr == TX_CTRL_ADDR) | (i_araddr == RX_CTRL_ADDR) |
                  (i_araddr == TX_HOLD_ADDR) | (i_araddr == RX_HOLD_ADDR) |
                  (i_araddr == IRQ_CTRL_ADDR);
   assign hold_wr = wr_go & i_wstrb[0] & (i_awaddr == TX_HOLD_ADDR);
   assign rxh_rd = rd_go & (i_araddr == RX_HOLD_ADDR);

   always_comb begin
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      rvalid_d = rvalid_q;
      rresp_d = rresp_q;
      rdata_d = rdata_q;
      if (bvalid_q && i_bready) begin
         bvalid_d = 1'b0;
      end
      if (wr_go) begin
         bvalid_d = 1'b1;
         bresp_d = aw_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (rvalid_q && i_rready) begin
         rvalid_d = 1'b0;
      end
      if (rd_go) begin
         rvalid_d = 1'b1;
         rresp_d = ar_ok ? RESP_OKAY : RESP_SLVERR;
         rdata_d = 32'h0;
         case (i_araddr)
            TX_CTRL_ADDR: begin
               rdata_d[7:0] = tx_ctrl_q;
               rdata_d[TX_SHIFT_EMPTY_POS] = (tx_st_q == TX_IDLE);
            end
            // ninth bit and error in status
            RX_CTRL_ADDR: begin
               rdata_d[7:0] = rx_ctrl_q;
               rdata_d[RX_NINTH_POS] = rxh_q.ninth;
               rdata_d[OVERRUN_POS] = overrun_q;
            end
            TX_HOLD_ADDR: rdata_d[7:0] = hold_q.data;
            RX_HOLD_ADDR: rdata_d[7:0] = rxh_q.data;
            IRQ_CTRL_ADDR: begin
               rdata_d[2:0] = irq_ctrl_q;
               rdata_d[TX_FLAG_POS] = tx_flag_q;
               rdata_d[RX_FLAG_POS] = rx_flag_q;
            end
            default: rdata_d = 32'h0;
         endcase
      end
   end

   // =========================================================================
   // Control registers
   // =========================================================================
   always_comb begin
      tx_ctrl_d = tx_ctrl_q;
      rx_ctrl_d = rx_ctrl_q;
      irq_ctrl_d = irq_ctrl_q;
      if (wr_go && i_wstrb[0]) begin
         case (i_awaddr)
            TX_CTRL_ADDR: tx_ctrl_d = i_wdata[7:0] & 8'hf1;
            RX_CTRL_ADDR: rx_ctrl_d = i_wdata[7:0] & 8'hf0;
            IRQ_CTRL_ADDR: irq_ctrl_d = i_wdata[2:0];
            default: ;
         endcase
      end
   end

   // =========================================================================
   // Transmit engine
   // =========================================================================
   // The last bit is the ninth in 9-bit mode and the eighth otherwise.
   assign tx_last = (tx_cnt_q == (cfg.tx_nine ? 4'h8 : 4'h7));

   always_comb begin
      tx_st_d = tx_st_q;
      tsr_d = tsr_q;
      tx_cnt_d = tx_cnt_q;
      hold_d = hold_q;
      hold_full_d = hold_full_q;
      tx_flag_d = tx_flag_q;
      if (hold_wr) begin
         hold_d = '{ninth: tx_ctrl_q[TX_NINTH_POS], data: i_wdata[7:0]};
         hold_full_d = 1'b1;
         tx_flag_d = 1'b0;
      end
      case (tx_st_q)
         TX_IDLE: begin
            // occupied holding register loads an idle shifter at once
            if (hold_full_q && active && cfg.tx_en) begin
               tsr_d = hold_q;
               tx_cnt_d = 4'h0;
               hold_full_d = hold_wr;
               tx_flag_d = ~hold_wr;
               tx_st_d = TX_SHIFT;
            end
         end
         TX_SHIFT: begin
            if (!active || !cfg.tx_en) begin
               tx_st_d = TX_IDLE;
            end else if (ck_fall) begin
               if (tx_last) begin
                  // second word waits until the shifter empties
                  tx_st_d = TX_LOAD;
               end else begin
                  tsr_d.data = {tsr_q.ninth, tsr_q.data[7:1]};
                  tx_cnt_d = tx_cnt_q + 4'h1;
               end
            end
         end
         TX_LOAD: tx_st_d = TX_IDLE;
         default: tx_st_d = TX_IDLE;
      endcase
   end

   // ninth bit shifted after data; pin held high outside TX_SHIFT
   assign o_tx_data_pin = (tx_st_q == TX_SHIFT) ? tsr_q.data[0] : 1'b1;
   assign o_tx_data_oe = active & cfg.tx_en;

   // =========================================================================
   // Receive engine
   // =========================================================================
   always_comb begin
      rsr_d = rsr_q;
      rx_cnt_d = rx_cnt_q;
      rxh_d = rxh_q;
      rx_flag_d = rx_flag_q & ~rxh_rd;
      overrun_d = overrun_q;
      rx_done = 1'b0;
      if (active && cfg.cont_rx && ck_rise) begin
         rsr_d = {rx_level, rsr_q[8:1]};
         rx_cnt_d = rx_cnt_q + 4'h1;
         // ninth bit captured in 9-bit mode
         if (rx_cnt_q == (cfg.rx_nine ? 4'h8 : 4'h7)) begin
            rx_cnt_d = 4'h0;
            rx_done = 1'b1;
         end
      end
      if (rx_done) begin
         // full word moves to holding register
         rxh_d = cfg.rx_nine ? word_t'({rx_level, rsr_q[8:1]}) :
                               word_t'({1'b0, rx_level, rsr_q[8:2]});
         if (rx_flag_q && !rxh_rd) begin
            overrun_d = 1'b1;
         end
         // receive done flag, set wins over read
         rx_flag_d = 1'b1;
      end
      if (!cfg.cont_rx) begin
         overrun_d = 1'b0;
         rx_cnt_d = 4'h0;
      end
   end

   // =========================================================================
   // Wake and interrupt
   // =========================================================================
   logic irq_any;
   // request only when the flag's own enable set
   assign irq_any = (tx_flag_q & irq_ctrl_q[TX_IE_POS]) | (rx_flag_q & irq_ctrl_q[RX_IE_POS]);
   assign o_wake = irq_any;
   assign o_irq_vector = irq_any & irq_ctrl_q[GIE_POS];

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         tx_ctrl_q <= TX_CTRL_RESET;
         rx_ctrl_q <= RX_CTRL_RESET;
         irq_ctrl_q <= IRQ_CTRL_RESET;
         hold_q <= '0;
         tsr_q <= '0;
         rxh_q <= '0;
         rsr_q <= '0;
         hold_full_q <= 1'b0;
         tx_flag_q <= 1'b1;
         rx_flag_q <= 1'b0;
         overrun_q <= 1'b0;
         tx_cnt_q <= 4'h0;
         rx_cnt_q <= 4'h0;
         tx_st_q <= TX_IDLE;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         rvalid_q <= 1'b0;
         rresp_q <= RESP_OKAY;
         rdata_q <= 32'h0;
      end else if (i_ce) begin
         tx_ctrl_q <= tx_ctrl_d;
         rx_ctrl_q <= rx_ctrl_d;
         irq_ctrl_q <= irq_ctrl_d;
         hold_q <= hold_d;
         tsr_q <= tsr_d;
         rxh_q <= rxh_d;
         rsr_q <= rsr_d;
         hold_full_q <= hold_full_d;
         tx_flag_q <= tx_flag_d;
         rx_flag_q <= rx_flag_d;
         overrun_q <= overrun_d;
         tx_cnt_q <= tx_cnt_d;
         rx_cnt_q <= rx_cnt_d;
         tx_st_q <= tx_st_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         rvalid_q <= rvalid_d;
         rresp_q <= rresp_d;
         rdata_q <= rdata_d;
      end
   end

   assign o_bvalid = bvalid_q;
   assign o_bresp = bresp_q;
   assign o_rvalid = rvalid_q;
   assign o_rresp = rresp_q;
   assign o_rdata = rdata_q;
endmodule
`default_nettype wire

// [usart_slave_props.sv]
// Port-level timing checker for the synchronous slave USART.
`timescale 1ns/1ps
`default_nettype none
module usart_slave_props
   import usart_slave_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_shift_clock_pin,
   input wire logic o_tx_data_pin,
   input wire logic o_wake,
   input wire logic o_irq_vector,
   input wire logic i_awvalid,
   input wire logic o_awready,
   input wire logic i_wvalid,
   input wire logic o_wready,
   input wire logic [1:0] o_bresp,
   input wire logic o_bvalid,
   input wire logic i_bready,
   input wire logic [7:0] i_araddr,
   input wire logic i_arvalid,
   input wire logic o_arready,
   input wire logic [31:0] o_rdata,
   input wire logic [1:0] o_rresp,
   input wire logic o_rvalid,
   input wire logic i_rready
);
   // ==========================================================================
   // Bus handshake
   // ==========================================================================
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   sequence s_wr_taken;
      i_awvalid && i_wvalid && !o_bvalid;
   endsequence
   sequence s_rd_taken;
      i_arvalid && !o_rvalid;
   endsequence
   a_write_answer_next: assert property (s_wr_taken |-> o_awready && o_wready ##1 o_bvalid)
      else $error("write not answered one cycle after it was taken");
   a_read_answer_next: assert property (s_rd_taken |-> o_arready ##1 o_rvalid)
      else $error("read not answered one cycle after it was taken");
   a_bresp_stands: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("write response dropped or changed before bready");
   a_rdata_stands: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read data dropped or changed before rready");
   a_unmapped_slverr: assert property (s_rd_taken ##0 i_araddr > 8'h10 |=> o_rresp == RESP_SLVERR)
      else $error("unmapped read not answered with slave error");
   a_upper_bits_zero: assert property (o_rvalid |-> o_rdata[31:8] == 24'h0)
      else $error("read data has bits above the low byte set");
   // ==========================================================================
   // Interrupt and link
   // ==========================================================================
   a_vector_needs_wake: assert property (o_irq_vector |-> o_wake)
      else $error("vector raised without wake");
   a_tx_moves_clk_low: assert property ($changed(o_tx_data_pin) |-> !i_shift_clock_pin)
      else $error("transmit pin changed while shift clock high");
endmodule
bind usart_sync_slave usart_slave_props u_props (.i_clk(i_clk), .i_nrst(i_nrst),
   .i_shift_clock_pin(i_shift_clock_pin), .o_tx_data_pin(o_tx_data_pin), .o_wake(o_wake),
   .o_irq_vector(o_irq_vector), .i_awvalid(i_awvalid), .o_awready(o_awready),
   .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
   .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
   .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready));
`default_nettype wire

// [usart_master_model.sv]
// Behavioural external synchronous master that owns the shift clock.
`timescale 1ns/1ps
`default_nettype none
module usart_master_model (
   output logic o_sck,
   output logic o_sdo,
   input wire logic i_sdi
);
   initial begin
      o_sck = 1'b0;
      o_sdo = 1'b1;
   end
   // master drives clock: clock rests low between frames, data LSB first.
   task automatic frame(input logic [8:0] w, input int n, input realtime half,
                        output logic [8:0] got);
      got = 9'h000;
      for (int i = 0; i < n; i++) begin
         o_sdo = w[i];
         #(half);
         o_sck = 1'b1;
         got[i] = i_sdi;
         #(half);
         o_sck = 1'b0;
      end
      // The data line is inverted, so it no longer shows the last bit.
      o_sdo = ~o_sdo;
      // The clock rests for half a period so the slave sees the last fall.
      #(half);
   endtask
endmodule
`default_nettype wire

// [usart_sync_slave_test.sv]
// Self-checking testbench for the synchronous slave USART.
`timescale 1ns/1ps
`default_nettype none
module usart_sync_slave_test
   import usart_slave_pkg::*;
;
   logic i_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic i_sleep = 1'b0;
   logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
   logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
   logic [31:0] i_wdata = 32'h0;
   logic [3:0] i_wstrb = 4'hf;
   logic sck, sdo, o_tx_data_pin, o_tx_data_oe, o_wake, o_irq_vector;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   logic [1:0] o_bresp, o_rresp, rd_resp, wr_resp;
   logic [31:0] o_rdata, rd_data;
   logic [8:0] got;
   int fails = 0;
   int tests_run = 0;
   always #5 i_clk = ~i_clk;
   usart_sync_slave uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(1'b1), .i_sleep(i_sleep),
      .i_shift_clock_pin(sck), .i_rx_data_pin(sdo), .o_tx_data_pin(o_tx_data_pin),
      .o_tx_data_oe(o_tx_data_oe), .o_wake(o_wake), .o_irq_vector(o_irq_vector),
      .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata),
      .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp),
      .o_bvalid(o_bvalid), .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
      .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
      .i_rready(i_rready));
   usart_master_model mdl (.o_sck(sck), .o_sdo(sdo), .i_sdi(o_tx_data_pin));
   // ==========================================================================
   // Bus tasks
   // ==========================================================================
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_awaddr <= a;
      i_wdata <= d;
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
      do @(posedge i_clk); while (o_awready !== 1'b1);
      i_awvalid <= 1'b0;
      i_wvalid <= 1'b0;
      do @(posedge i_clk); while (o_bvalid !== 1'b1);
      wr_resp = o_bresp;
      i_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge i_clk);
      i_araddr <= a;
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
      do @(posedge i_clk); while (o_arready !== 1'b1);
      i_arvalid <= 1'b0;
      do @(posedge i_clk); while (o_rvalid !== 1'b1);
      rd_data = o_rdata;
      rd_resp = o_rresp;
      i_rready <= 1'b0;
   endtask
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      rd(a);
      chk($sformatf("register %h", a), exp, rd_data);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      #100us;
      fails++;
      wrap_up();
   end
   // ==========================================================================
   // Tests
   // ==========================================================================
   initial begin
      repeat (6) @(posedge i_clk);
      i_nrst <= 1'b1;
      rchk(TX_CTRL_ADDR, 32'h02);
      rchk(IRQ_CTRL_ADDR, 32'h10);
      rd(8'h14);
      chk("unmapped response", {30'h0, RESP_SLVERR}, {30'h0, rd_resp});
      wr(8'h14, 32'hff);
      chk("unmapped write response", {30'h0, RESP_SLVERR}, {30'h0, wr_resp});
      chk("output enable idle", 32'h0, {31'h0, o_tx_data_oe});
      i_wstrb <= 4'he;
      wr(IRQ_CTRL_ADDR, 32'h07);
      i_wstrb <= 4'hf;
      rchk(IRQ_CTRL_ADDR, 32'h10);
      wr(RX_CTRL_ADDR, 32'h80);
      wr(TX_CTRL_ADDR, 32'hb0);
      chk("master mode output enable", 32'h0, {31'h0, o_tx_data_oe});
      wr(TX_CTRL_ADDR, 32'h30);
      chk("write response", {30'h0, RESP_OKAY}, {30'h0, wr_resp});
      wr(IRQ_CTRL_ADDR, 32'h05);
      chk("output enable", 32'h1, {31'h0, o_tx_data_oe});
      i_sleep <= 1'b1;
      wr(TX_HOLD_ADDR, 32'ha5);
      wr(TX_HOLD_ADDR, 32'h3c);
      rchk(IRQ_CTRL_ADDR, 32'h05);
      chk("wake while held", 32'h0, {31'h0, o_wake});
      mdl.frame(9'h000, 8, 62.5, got);
      chk("first word", 32'ha5, {23'h0, got});
      idle(10);
      rchk(IRQ_CTRL_ADDR, 32'h15);
      chk("tx wake and vector", 32'h3, {30'h0, o_wake, o_irq_vector});
      mdl.frame(9'h000, 8, 62.5, got);
      chk("second word", 32'h3c, {23'h0, got});
      i_sleep <= 1'b0;
      wr(TX_CTRL_ADDR, 32'h71);
      wr(TX_HOLD_ADDR, 32'h5a);
      mdl.frame(9'h000, 9, 62.5, got);
      chk("nine bit word", 32'h15a, {23'h0, got});
      i_sleep <= 1'b1;
      wr(TX_CTRL_ADDR, 32'h10);
      wr(IRQ_CTRL_ADDR, 32'h06);
      wr(RX_CTRL_ADDR, 32'hb0);
      mdl.frame(9'h096, 8, 62.5, got);
      idle(10);
      chk("rx wake and vector", 32'h3, {30'h0, o_wake, o_irq_vector});
      rchk(IRQ_CTRL_ADDR, 32'h36);
      rchk(RX_CTRL_ADDR, 32'hb0);
      rchk(RX_HOLD_ADDR, 32'h96);
      rchk(IRQ_CTRL_ADDR, 32'h16);
      mdl.frame(9'h011, 8, 62.5, got);
      mdl.frame(9'h022, 8, 62.5, got);
      idle(10);
      rchk(RX_CTRL_ADDR, 32'hb2);
      wr(RX_CTRL_ADDR, 32'h80);
      rchk(RX_CTRL_ADDR, 32'h80);
      rd(RX_HOLD_ADDR);
      wr(RX_CTRL_ADDR, 32'hd0);
      mdl.frame(9'h1c3, 9, 62.5, got);
      idle(10);
      rchk(RX_CTRL_ADDR, 32'hd1);
      rchk(RX_HOLD_ADDR, 32'hc3);
      wrap_up();
   end
endmodule
`default_nettype wire
